// File: hdl/pmrp_pkg.sv
package pmrp_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [3:0] PMRP_OFF_CTRL = 4'h0;
  localparam logic [3:0] PMRP_OFF_STAT = 4'h4;
  localparam logic [3:0] PMRP_OFF_ERRCNT = 4'h8;
  localparam int PMRP_CTRL_MODE_LSB = 0;
  localparam int PMRP_CTRL_SPD100_BIT = 2;
  localparam int PMRP_CTRL_FDX_BIT = 3;
  localparam int PMRP_CTRL_HB_BIT = 4;
  localparam logic [4:0] PMRP_CTRL_RST = 5'h04;
  localparam logic [1:0] PMRP_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMRP_RESP_SLVERR = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int PMRP_ACLK_NS = 50;
  localparam int PMRP_MII100_HALF_NS = 20;  // 25 MHz receive clock
  localparam int PMRP_MII10_HALF_NS = 200;  // 2.5 MHz receive clock
  localparam int PMRP_SNI_HALF_NS = 50;  // 10 MHz receive clock
  localparam int PMRP_SQE_NS = 1000;
  // half periods round down, but never below one cycle
  localparam int PMRP_MII100_HALF_CYC = (PMRP_MII100_HALF_NS / PMRP_ACLK_NS) < 1 ? 1 :
    PMRP_MII100_HALF_NS / PMRP_ACLK_NS;
  localparam int PMRP_MII10_HALF_CYC = (PMRP_MII10_HALF_NS / PMRP_ACLK_NS) < 1 ? 1 :
    PMRP_MII10_HALF_NS / PMRP_ACLK_NS;
  localparam int PMRP_SNI_HALF_CYC = (PMRP_SNI_HALF_NS / PMRP_ACLK_NS) < 1 ? 1 :
    PMRP_SNI_HALF_NS / PMRP_ACLK_NS;
  localparam int PMRP_SQE_CYC = (PMRP_SQE_NS / PMRP_ACLK_NS) < 1 ? 1 :
    PMRP_SQE_NS / PMRP_ACLK_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PMRP_MII, PMRP_RMII, PMRP_SNI} pmrp_mode_t;
  typedef enum logic [1:0] {PMRP_R_CTRL, PMRP_R_STAT, PMRP_R_ERRCNT, PMRP_R_NONE} pmrp_reg_t;

  typedef struct packed {
    logic carrier;
    logic valid;
    logic [3:0] nib;
    logic sym_err;
    logic false_carrier;
  } pmrp_core_rx_t;

  typedef struct packed {
    logic rx_clk;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic col;
  } pmrp_mac_rx_t;

endpackage : pmrp_pkg

// File: hdl/pmrp_rx_port.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps

// Overview of operation
// (R01) mii receive clock 25 or 2.5 MHz; at 100 the code gives 10 MHz, its half period held at one 50 ns aclk
// (R02) rmii times receive on 50 MHz reference
// (R03) sni receive clock is 10 MHz
// (R04) mii data valid high with valid nibbles
// (R05) rmii still drives data valid
// (R06) sni leaves data valid and error low
// (R07) mii 100 error on invalid symbol
// (R08) rmii 100 error on invalid symbol in frame
// (R09) rmii error also on false carrier
// (R10) rmii corrupts data on receive error
// (R11) mii nibble data on receive clock
// (R12) rmii dibit data on reference clock
// (R13) sni serial bit, upper lines unused
// (R14) mii and sni carrier sense while busy
// (R15) rmii merged carrier and data valid
// (R16) mii half duplex collision on overlap
// (R17) 10 half heartbeat pulse after transmit
// (R18) full duplex collision always zero
// (R19) rmii mac derives collision itself
// (R20) sni 10 Mb collision on overlap
// (R21) mode, speed, duplex, heartbeat static config
module pmrp_rx_port #(
  parameter int HB_CYCLES = pmrp_pkg::PMRP_SQE_CYC,
  parameter int ERRCNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pmrp_pkg::pmrp_core_rx_t core_rx,
  output logic core_ready,
  input wire logic reference_clock_in,
  input wire logic mac_tx_en,
  output pmrp_pkg::pmrp_mac_rx_t mac_rx
);
  import pmrp_pkg::*;

  if (HB_CYCLES < 1 || HB_CYCLES > 255) begin : g_chk_hb
    $error("HB_CYCLES must lie in 1..255");
  end
  if (ERRCNT_W < 1 || ERRCNT_W > 32) begin : g_chk_cnt
    $error("ERRCNT_W must lie in 1..32");
  end

  // ****************************************
  // register decode
  // ****************************************
  function automatic pmrp_reg_t pmrp_dec(input logic [3:0] a);
    unique case (a)
      PMRP_OFF_CTRL: pmrp_dec = PMRP_R_CTRL;
      PMRP_OFF_STAT: pmrp_dec = PMRP_R_STAT;
      PMRP_OFF_ERRCNT: pmrp_dec = PMRP_R_ERRCNT;
      default: pmrp_dec = PMRP_R_NONE;
    endcase
  endfunction : pmrp_dec

  logic [4:0] ctrl_q;
  logic aw_have_q, w_have_q, w_strb0_q, bvalid_q, rvalid_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [ERRCNT_W-1:0] errcnt_q;

  // one write at a time: both halves are refused while a response waits
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb0_q <= 1'b0;
    end else if (aw_have_q && w_have_q) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // write commit and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= PMRP_CTRL_RST;
      bvalid_q <= 1'b0;
      bresp_q <= PMRP_RESP_OKAY;
    end else if (aw_have_q && w_have_q) begin
      bvalid_q <= 1'b1;
      bresp_q <= PMRP_RESP_OKAY;
      unique case (pmrp_dec(aw_addr_q))
        PMRP_R_CTRL: if (w_strb0_q) ctrl_q <= w_data_q[4:0];  // see (R21)
        PMRP_R_STAT, PMRP_R_ERRCNT: ;  // read-only, write ignored
        PMRP_R_NONE: bresp_q <= PMRP_RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  pmrp_mode_t mode;
  logic spd100, fdx, hb_en;

  // the unused mode code falls back to mii
  always_comb begin
    mode = PMRP_MII;  // see (R21)
    unique case (ctrl_q[PMRP_CTRL_MODE_LSB +: 2])
      2'h1: mode = PMRP_RMII;
      2'h2: mode = PMRP_SNI;
      default: mode = PMRP_MII;
    endcase
  end
  assign spd100 = ctrl_q[PMRP_CTRL_SPD100_BIT];
  assign fdx = ctrl_q[PMRP_CTRL_FDX_BIT];
  assign hb_en = ctrl_q[PMRP_CTRL_HB_BIT];

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic tx_s1_q, tx_s2_q, tx_s3_q;
  logic ref_rise, tx_fall;

  // two stages before any logic looks at a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      tx_s1_q <= 1'b0;
      tx_s2_q <= 1'b0;
      tx_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= reference_clock_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      tx_s1_q <= mac_tx_en;
      tx_s2_q <= tx_s1_q;
      tx_s3_q <= tx_s2_q;
    end
  end
  assign ref_rise = ref_s2_q && !ref_s3_q;
  assign tx_fall = tx_s3_q && !tx_s2_q;

  // ****************************************
  // receive clock and delivery tick
  // ****************************************
  logic [7:0] div_q, half_cyc;
  logic rx_clk_q, tick;

  // half period chosen by mode and speed
  always_comb begin
    if (mode == PMRP_SNI) begin
      half_cyc = 8'(PMRP_SNI_HALF_CYC);  // see (R03)
    end else if (spd100) begin
      half_cyc = 8'(PMRP_MII100_HALF_CYC);  // see (R01)
    end else begin
      half_cyc = 8'(PMRP_MII10_HALF_CYC);  // see (R01)
    end
  end

  // clock held low in rmii, where the reference paces everything
  always_ff @(posedge aclk) begin
    if (!aresetn || mode == PMRP_RMII) begin  // see (R02)
      div_q <= 8'h0;
      rx_clk_q <= 1'b0;
    end else if (div_q >= half_cyc - 8'h1) begin
      div_q <= 8'h0;
      rx_clk_q <= !rx_clk_q;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end

  // data moves on the falling receive clock, half a period before the mac samples
  assign tick = (mode == PMRP_RMII) ? ref_rise :  // see (R12)
    (rx_clk_q && div_q >= half_cyc - 8'h1);  // see (R11) (R13)

  // ****************************************
  // nibble splitting
  // ****************************************
  logic [3:0] sh_q, src;
  logic [2:0] left_q, step;
  logic err_q, take, src_err, busy;

  always_comb begin
    unique case (mode)
      PMRP_MII: step = 3'd4;
      PMRP_RMII: step = 3'd2;
      PMRP_SNI: step = 3'd1;
    endcase
  end

  // a new nibble is taken only when the previous one is fully shifted out
  assign core_ready = tick && left_q == 3'd0;
  assign take = core_ready && core_rx.valid;
  assign busy = left_q != 3'd0;
  assign src = busy ? sh_q : core_rx.nib;
  assign src_err = busy ? err_q : core_rx.sym_err;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q <= 4'h0;
      left_q <= 3'd0;
      err_q <= 1'b0;
    end else if (tick && (take || busy)) begin
      sh_q <= src >> step;
      left_q <= busy ? left_q - step : 3'd4 - step;
      err_q <= src_err;
    end
  end

  // ****************************************
  // receive outputs
  // ****************************************
  logic [3:0] out_bits;
  logic dv_d, er_d, crs_d;

  always_comb begin
    out_bits = 4'h0;
    unique case (mode)
      PMRP_MII: out_bits = src;  // see (R11)
      PMRP_RMII: out_bits = {2'b00, src[1:0] ^ {2{src_err && spd100}}};  // see (R10) (R12)
      PMRP_SNI: out_bits = {3'b000, src[0]};  // see (R13)
    endcase
  end

  always_comb begin
    dv_d = (take || busy) && mode != PMRP_SNI;  // see (R04) (R05) (R06)
    er_d = 1'b0;
    crs_d = core_rx.carrier;  // see (R14)
    unique case (mode)
      PMRP_MII: er_d = spd100 && (take || busy) && src_err;  // see (R07)
      PMRP_RMII: begin
        crs_d = core_rx.carrier || take || busy;  // see (R15)
        er_d = (spd100 && crs_d && (take || busy) && src_err)  // see (R08)
          || core_rx.false_carrier;  // see (R09)
      end
      PMRP_SNI: er_d = 1'b0;  // see (R06)
    endcase
  end
  logic [3:0] rxd_q;
  logic dv_q, er_q, crs_q;

  // data, valid, error and carrier pins change only on the delivery tick; clock and collision do not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q <= 4'h0;
      dv_q <= 1'b0;
      er_q <= 1'b0;
      crs_q <= 1'b0;
    end else if (tick) begin
      rxd_q <= (take || busy) ? out_bits : 4'h0;
      dv_q <= dv_d;
      er_q <= er_d;
      crs_q <= crs_d;
    end
  end

  // ****************************************
  // collision and heartbeat
  // ****************************************
  logic [7:0] hb_q;
  logic col_d, col_q;

  // sqe test pulse: only 10 Mb half duplex with heartbeat on
  always_ff @(posedge aclk) begin
    if (!aresetn || fdx || mode == PMRP_RMII) begin  // see (R18)
      hb_q <= 8'h0;
    end else if (tx_fall && !spd100 && hb_en) begin
      hb_q <= 8'(HB_CYCLES);  // see (R17)
    end else if (hb_q != 8'h0) begin
      hb_q <= hb_q - 8'h1;
    end
  end

  // rmii has no collision pin; the mac works it out from crs_dv
  always_comb begin
    col_d = 1'b0;
    unique case (mode)
      PMRP_MII: col_d = tx_s2_q && core_rx.carrier;  // see (R16)
      PMRP_SNI: col_d = !spd100 && tx_s2_q && core_rx.carrier;  // see (R20)
      PMRP_RMII: col_d = 1'b0;  // see (R19)
    endcase
    col_d = !fdx && (col_d || hb_q != 8'h0);  // see (R17) (R18)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col_q <= 1'b0;
    end else begin
      col_q <= col_d;
    end
  end
  // packed order follows the struct: clock, data, valid, error, carrier, collision
  assign mac_rx = {rx_clk_q, rxd_q, dv_q, er_q, crs_q, col_q};

  // ****************************************
  // error count and reads
  // ****************************************
  // counts delivered error ticks; wraps silently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      errcnt_q <= '0;
    end else if (tick && er_d) begin
      errcnt_q <= errcnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= PMRP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= PMRP_RESP_OKAY;
      rdata_q <= 32'h0;
      unique case (pmrp_dec(s_axi_araddr))
        PMRP_R_CTRL: rdata_q <= {27'h0, ctrl_q};
        PMRP_R_STAT: rdata_q <= {26'h0, busy, crs_q, col_q, er_q, dv_q, rx_clk_q};
        PMRP_R_ERRCNT: rdata_q <= 32'(errcnt_q);
        PMRP_R_NONE: rresp_q <= PMRP_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : pmrp_rx_port

// File: tb/pmrp_mac_model.sv
`timescale 1ns/10ps
module pmrp_mac_model (
  input wire logic [1:0] mode,
  input wire logic tx_go,
  input wire logic reference_clock_in,
  output logic mac_tx_en,
  input wire pmrp_pkg::pmrp_mac_rx_t mac_rx
);
  import pmrp_pkg::*;
  logic [3:0] got [$];
  logic own_col;
  // transmit enable follows the bench's command
  assign mac_tx_en = tx_go;
  // rmii gives no collision pin, the mac works it out itself
  assign own_col = (mode == 2'h1) && mac_tx_en && mac_rx.crs;
  // mii nibbles and sni bits taken on the rising receive clock
  always @(posedge mac_rx.rx_clk) begin
    if (mode == 2'h0 && mac_rx.rx_dv) got.push_back(mac_rx.rxd);
    else if (mode == 2'h2 && mac_rx.crs) got.push_back({3'h0, mac_rx.rxd[0]});
  end
  // rmii dibits taken on the shared reference
  always @(posedge reference_clock_in) begin
    if (mode == 2'h1 && mac_rx.rx_dv) got.push_back({2'h0, mac_rx.rxd[1:0]});
  end
endmodule : pmrp_mac_model

// File: tb/pmrp_rx_port_assertions.sv
`timescale 1ns/10ps
module pmrp_rx_port_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire pmrp_pkg::pmrp_core_rx_t core_rx,
  input wire logic core_ready,
  input wire pmrp_pkg::pmrp_mac_rx_t mac_rx
);
  import pmrp_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] adr_q;
  logic [4:0] dat_q;
  logic [4:0] cfg_q;
  logic stb_q;
  logic bv_q;
  logic [3:0] age_q;
  logic ok;
  logic rmii;
  logic sni;
  logic mii;
  // ****************************************
  // shadow of the control word
  // ****************************************
  // age gate: data, valid, error and carrier pins only follow a new config at the next tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= PMRP_CTRL_RST;
      age_q <= 4'h0;
      bv_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata[4:0];
      if (s_axi_wvalid && s_axi_wready) stb_q <= s_axi_wstrb[0];
      bv_q <= s_axi_bvalid;
      if (s_axi_bvalid && !bv_q && adr_q == PMRP_OFF_CTRL && stb_q) begin
        cfg_q <= dat_q;
        age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
        age_q <= age_q + 4'h1;
      end
    end
  end
  // mode decode, code 3 acts as mii
  assign ok = age_q == 4'hf;
  assign rmii = cfg_q[1:0] == 2'h1;
  assign sni = cfg_q[1:0] == 2'h2;
  assign mii = !rmii && !sni;
  // ****************************************
  // sequences and properties
  // ****************************************
  sequence take_s;
    core_ready && core_rx.valid;
  endsequence
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  mii_nib_a : assert property ((ok && mii) ##0 take_s |=> mac_rx.rx_dv &&
    mac_rx.rxd == $past(core_rx.nib) && mac_rx.rx_er == ($past(core_rx.sym_err) && cfg_q[2]))
    else $error("mii nibble not delivered");
  rmii_err_a : assert property ((ok && rmii && cfg_q[2]) ##0 take_s ##0 core_rx.sym_err
    |=> mac_rx.rx_er && mac_rx.rxd[1:0] == ($past(core_rx.nib[1:0]) ^ 2'h3))
    else $error("rmii error dibit wrong");
  rmii_fc_a : assert property (ok && rmii && $rose(core_rx.false_carrier)
    |-> ##[1:12] mac_rx.rx_er) else $error("false carrier not flagged");
  sni_quiet_a : assert property (ok && sni |-> !mac_rx.rx_dv && !mac_rx.rx_er &&
    mac_rx.rxd[3:1] == 3'h0) else $error("sni unused lines active");
  rmii_noclk_a : assert property (ok && rmii |-> !mac_rx.rx_clk && !mac_rx.col)
    else $error("rmii clock or collision active");
  fdx_nocol_a : assert property (ok && cfg_q[3] |-> !mac_rx.col)
    else $error("collision in full duplex");
  sni_col_a : assert property (ok && sni && cfg_q[2] |-> !mac_rx.col)
    else $error("sni collision at 100");
  wr_answer_a : assert property (wr_take_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule : pmrp_rx_port_assertions

bind pmrp_rx_port pmrp_rx_port_assertions chk (.*);

// File: tb/pmrp_rx_port_tb_top.sv
`timescale 1ns/10ps
module pmrp_rx_port_tb_top;
  import pmrp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic ref_clk = 0;
  logic tx_go = 0;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, core_ready, mac_tx_en;
  logic [1:0] bresp, rresp, rs;
  logic [1:0] md = 2'h0;
  logic [31:0] rdata, rd;
  pmrp_core_rx_t core_rx = '0;
  pmrp_mac_rx_t mac_rx;
  int mismatches = 0, compares = 0, cycles = 0, n;
  realtime t0;
  logic [4:0] ct [5] = '{5'h04, 5'h0c, 5'h02, 5'h05, 5'h06};
  logic [4:0] ht [3] = '{5'h10, 5'h18, 5'h00};
  int ce [5] = '{1, 0, 1, 0, 0};
  int me [5] = '{0, 0, 0, 1, 0};
  int he [3] = '{3, 0, 0};

  always #25 aclk = ~aclk;
  // reference runs free, offset so it never meets an aclk edge
  initial begin
    #7;
    forever #200 ref_clk = ~ref_clk;
  end
  pmrp_rx_port #(.HB_CYCLES(3)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_rx(core_rx), .core_ready(core_ready), .reference_clock_in(ref_clk),
    .mac_tx_en(mac_tx_en), .mac_rx(mac_rx));
  pmrp_mac_model mac (.mode(md), .tx_go(tx_go), .reference_clock_in(ref_clk),
    .mac_tx_en(mac_tx_en), .mac_rx(mac_rx));

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task conclude;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        bready <= 0;
        done = 1;
      end
    end
    @(posedge aclk);
  endtask : axi_wr
  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 0;
        done = 1;
      end
    end
    @(posedge aclk);
  endtask : axi_rd
  // config only while idle, then let the port settle
  task cfg(input logic [4:0] c);
    axi_wr(PMRP_OFF_CTRL, {27'h0, c}, rs);
    md <= (c[1:0] == 2'h3) ? 2'h0 : c[1:0];
    repeat (20) @(posedge aclk);
  endtask : cfg
  task per(input int ns);
    @(posedge mac_rx.rx_clk);
    t0 = $realtime;
    @(posedge mac_rx.rx_clk);
    chk("rx_clk_ns", ns, int'($realtime - t0));
  endtask : per
  // four nibbles, expected wire units built from the mode
  task frame(input logic [15:0] d, input logic [3:0] e, input logic spd);
    logic [3:0] exq [$];
    logic [3:0] nb;
    logic [1:0] x;
    exq = {};
    mac.got.delete();
    core_rx.carrier <= 1;
    for (int i = 0; i < 4; i++) begin
      nb = d[4*i +: 4];
      x = {2{e[i] & spd}};
      core_rx.valid <= 1;
      core_rx.nib <= nb;
      core_rx.sym_err <= e[i];
      if (md == 2'h0) exq.push_back(nb);
      else if (md == 2'h1) begin
        exq.push_back({2'h0, nb[1:0] ^ x});
        exq.push_back({2'h0, nb[3:2] ^ x});
      end else for (int b = 0; b < 4; b++) exq.push_back({3'h0, nb[b]});
      do @(negedge aclk); while (core_ready !== 1'b1);
      @(posedge aclk);
    end
    core_rx.valid <= 0;
    core_rx.sym_err <= 0;
    repeat (40) @(posedge aclk);
    core_rx.carrier <= 0;
    repeat (10) @(posedge aclk);
    for (int i = 0; i < exq.size(); i++) chk("rx_unit", exq[i], mac.got[i]);
  endtask : frame

  // ****************************************
  // timeout and main sequence
  // ****************************************
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    axi_rd(PMRP_OFF_CTRL, rd, rs);
    chk("ctrl_reset", 32'h4, rd);
    axi_rd(4'hc, rd, rs);
    chk("unmapped_rd", {30'h0, PMRP_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped_data", 32'h0, rd);
    axi_wr(4'hc, 32'h1, rs);
    chk("unmapped_wr", {30'h0, PMRP_RESP_SLVERR}, {30'h0, rs});
    axi_wr(PMRP_OFF_STAT, 32'h1f, rs);
    chk("stat_wr", {30'h0, PMRP_RESP_OKAY}, {30'h0, rs});
    cfg(5'h04);
    per(2 * PMRP_MII100_HALF_CYC * PMRP_ACLK_NS);
    frame(16'h3c5a, 4'h2, 1'b1);
    cfg(5'h00);
    per(2 * PMRP_MII10_HALF_CYC * PMRP_ACLK_NS);
    frame(16'h96e1, 4'h1, 1'b0);
    cfg(5'h05);
    frame(16'h5a3c, 4'h4, 1'b1);
    core_rx.false_carrier <= 1;
    repeat (16) @(posedge aclk);
    core_rx.false_carrier <= 0;
    axi_rd(PMRP_OFF_ERRCNT, rd, rs);
    // one mii 100 error, two corrupted rmii dibits, two false carrier ticks in 16 cycles
    chk("errcnt", 32'd5, rd);
    cfg(5'h02);
    per(2 * PMRP_SNI_HALF_CYC * PMRP_ACLK_NS);
    frame(16'ha5c3, 4'h0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      cfg(ct[i]);
      core_rx.carrier <= 1;
      tx_go <= 1;
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      chk("col", ce[i], {31'h0, mac_rx.col});
      chk("crs", 32'h1, {31'h0, mac_rx.crs});
      chk("mac_col", me[i], {31'h0, mac.own_col});
      @(posedge aclk);
      tx_go <= 0;
      core_rx.carrier <= 0;
      repeat (10) @(posedge aclk);
    end
    for (int i = 0; i < 3; i++) begin
      cfg(ht[i]);
      tx_go <= 1;
      repeat (6) @(posedge aclk);
      tx_go <= 0;
      n = 0;
      repeat (40) begin
        @(negedge aclk);
        if (mac_rx.col === 1'b1) n++;
      end
      chk("sqe_cycles", he[i], n);
    end
    conclude();
  end
endmodule : pmrp_rx_port_tb_top
